// File: core/l1_cache_line_lock_control.v
`timescale 1ns/1ps
`include "lock_ctrl_defines.vh"

module l1_cache_line_lock_control (
   // Clock and reset
   input wire clock,
   input wire arst_n,
   // AXI4-Lite write address and data
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Operation request from the pipeline
   input wire op_valid,
   input wire [3:0] op_code,
   input wire [`SET_BITS-1:0] op_index,
   input wire [4:0] cache_target_field,
   input wire user_privilege_flag,
   input wire user_lock_enable,
   // Lookup and translation results for the request, and the pending interrupt
   input wire line_hit,
   input wire [`WAY_BITS-1:0] hit_way,
   input wire tlb_miss,
   input wire perm_read,
   input wire perm_exec,
   input wire cache_inhibited,
   input wire interrupt_pending,
   // Operation result
   output reg op_ready,
   output reg op_done,
   output reg data_storage_fault,
   output reg dtlb_error,
   output reg fill_req,
   output reg fill_icache,
   output reg [`SET_BITS-1:0] fill_index,
   output reg [`WAY_BITS-1:0] fill_way
);

   // ****************************************
   // State
   // ****************************************
   // Lock arrays have no reset on purpose: they must survive it
   reg [`WAYS-1:0] dlock [0:`SETS-1];
   reg [`WAYS-1:0] ilock [0:`SETS-1];
   reg dc_enable, dc_alloc, dc_unable, dc_over, dc_flash, dc_abort;
   reg ic_enable, ic_alloc, ic_unable, ic_over, ic_flash, ic_abort;
   reg data_lock_syndrome, instr_lock_syndrome;
   reg [7:0] dc_count, ic_count;
   reg aw_held, w_held;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   integer i, j;
   // A flash start must drop op_ready at the very edge it is written
   wire flash_start = aw_held & w_held & ~s_axi_bvalid & w_strb[0] &
      w_data[`CSR_FLASH_CLEAR_BIT] & (aw_addr[7:3] == 5'h00);

   // ****************************************
   // Operation decode
   // ****************************************
   reg next_dsi, next_tlb, next_syn_d, next_syn_i;
   reg next_d_unable, next_d_over, next_i_unable, next_i_over;
   reg next_lock_wr, next_lock_val, next_fill;
   reg [`WAY_BITS-1:0] next_way;
   reg is_dset, is_dclr, is_iset, is_iclr, is_inv, on_icache;
   reg enabled, alloc, priv_fault, perm_ok, fire;
   reg [`WAYS-1:0] locks;
   reg [`WAY_BITS-1:0] victim;
   reg have_victim;

   always @* begin
      fire = op_valid & op_ready;
      is_dset = (op_code == `OP_DLOCK_SET) ||
                (op_code == `OP_DSTORE_LOCK_SET);
      is_dclr = (op_code == `OP_DLOCK_CLEAR);
      is_iset = (op_code == `OP_ILOCK_SET);
      is_iclr = (op_code == `OP_ILOCK_CLEAR);
      is_inv = (op_code == `OP_DFLUSH_INV) || (op_code == `OP_DINV) ||
               (op_code == `OP_IINV);
      on_icache = is_iset | is_iclr | (op_code == `OP_IINV);
      locks = on_icache ? ilock[op_index] : dlock[op_index];
      enabled = on_icache ? ic_enable : dc_enable;
      alloc = on_icache ? ic_alloc : dc_alloc;
      priv_fault = user_privilege_flag & ~user_lock_enable;
      perm_ok = on_icache ? (perm_read | perm_exec) : perm_read;
      // Lowest unlocked way; way 0 is displaced on an overlock allocate
      victim = {`WAY_BITS{1'b0}};
      have_victim = 1'b0;
      for (i = `WAYS - 1; i >= 0; i = i - 1) begin
         if (!locks[i]) begin
            victim = i[`WAY_BITS-1:0];
            have_victim = 1'b1;
         end
      end
      next_dsi = 1'b0;
      next_tlb = 1'b0;
      next_syn_d = 1'b0;
      next_syn_i = 1'b0;
      next_d_unable = 1'b0;
      next_d_over = 1'b0;
      next_i_unable = 1'b0;
      next_i_over = 1'b0;
      next_lock_wr = 1'b0;
      next_lock_val = 1'b0;
      next_fill = 1'b0;
      next_way = hit_way;
      // Checks run in precedence order; the first that applies wins
      if (fire && (is_dset || is_iset)) begin
         if ((|cache_target_field) || !enabled) begin
            next_d_unable = is_dset;
            next_i_unable = is_iset;
         end else if (tlb_miss) begin
            next_tlb = 1'b1;
         end else if (priv_fault) begin
            next_dsi = 1'b1;
            next_syn_d = is_dset;
            next_syn_i = is_iset;
         end else if (!perm_ok) begin
            next_dsi = 1'b1;
         end else if (cache_inhibited && !line_hit) begin
            next_d_unable = is_dset;
            next_i_unable = is_iset;
         end else if (line_hit) begin
            next_lock_wr = 1'b1;
            next_lock_val = 1'b1;
         end else if (!have_victim) begin
            next_d_over = is_dset;
            next_i_over = is_iset;
            next_lock_wr = alloc;
            next_lock_val = 1'b1;
            next_fill = alloc;
            next_way = {`WAY_BITS{1'b0}};
         end else begin
            next_lock_wr = 1'b1;
            next_lock_val = 1'b1;
            next_fill = 1'b1;
            next_way = victim;
         end
      end else if (fire && (is_dclr || is_iclr)) begin
         if ((|cache_target_field) || !enabled) begin
            next_lock_wr = 1'b0;
         end else if (tlb_miss) begin
            next_tlb = 1'b1;
         end else if (priv_fault) begin
            next_dsi = 1'b1;
            next_syn_d = is_dclr;
            next_syn_i = is_iclr;
         end else if (!perm_ok) begin
            next_dsi = 1'b1;
         end else begin
            next_lock_wr = line_hit;
         end
      end else if (fire && is_inv) begin
         next_lock_wr = line_hit & enabled & ~tlb_miss & perm_ok;
      end
      // Touch, allocate, zero and store-flush fall through untouched
   end

   // ****************************************
   // Lock arrays
   // ****************************************
   always @(posedge clock) begin
      if (next_lock_wr && on_icache) begin
         ilock[op_index][next_way] <= next_lock_val;
      end
      if (next_lock_wr && !on_icache) begin
         dlock[op_index][next_way] <= next_lock_val;
      end
      if (dc_flash && dc_count == 8'd1 && !interrupt_pending) begin
         for (j = 0; j < `SETS; j = j + 1) begin
            dlock[j] <= {`WAYS{1'b0}};
         end
      end
      if (ic_flash && ic_count == 8'd1 && !interrupt_pending) begin
         for (j = 0; j < `SETS; j = j + 1) begin
            ilock[j] <= {`WAYS{1'b0}};
         end
      end
   end

   // ****************************************
   // Operation results
   // ****************************************
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         op_ready <= 1'b0;
         op_done <= 1'b0;
         data_storage_fault <= 1'b0;
         dtlb_error <= 1'b0;
         fill_req <= 1'b0;
         fill_icache <= 1'b0;
         fill_index <= {`SET_BITS{1'b0}};
         fill_way <= {`WAY_BITS{1'b0}};
      end else begin
         // A request seen while ready is answered on the next edge
         op_ready <= ~(dc_flash | ic_flash | flash_start) & ~fire;
         op_done <= fire;
         data_storage_fault <= next_dsi;
         dtlb_error <= next_tlb;
         fill_req <= next_fill;
         fill_icache <= on_icache;
         fill_index <= op_index;
         fill_way <= next_way;
      end
   end

   // ****************************************
   // Register bus
   // ****************************************
   wire wr_go = aw_held & w_held & ~s_axi_bvalid;
   wire wr_d = wr_go & w_strb[0] & (aw_addr == `DCACHE_CTRL_OFFSET);
   wire wr_i = wr_go & w_strb[0] & (aw_addr == `ICACHE_CTRL_OFFSET);
   wire wr_s = wr_go & w_strb[0] & (aw_addr == `SYNDROME_OFFSET);
   wire wr_ok = (aw_addr == `DCACHE_CTRL_OFFSET) ||
                (aw_addr == `ICACHE_CTRL_OFFSET) ||
                (aw_addr == `SYNDROME_OFFSET);
   wire d_done = dc_flash & ((dc_count == 8'd1) | interrupt_pending);
   wire i_done = ic_flash & ((ic_count == 8'd1) | interrupt_pending);

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready <= ~w_held & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h3;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `DCACHE_CTRL_OFFSET: s_axi_rdata <= {26'h0, dc_abort,
                  dc_flash, dc_over, dc_unable, dc_alloc, dc_enable};
               `ICACHE_CTRL_OFFSET: s_axi_rdata <= {26'h0, ic_abort,
                  ic_flash, ic_over, ic_unable, ic_alloc, ic_enable};
               `SYNDROME_OFFSET: s_axi_rdata <= {30'h0,
                  instr_lock_syndrome, data_lock_syndrome};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h3;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // Control registers and flash clear
   // ****************************************
   // Hardware sets win over a software write of the same cycle
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         {dc_enable, dc_alloc, dc_unable, dc_over} <= 4'h0;
         {dc_flash, dc_abort} <= 2'h0;
         {ic_enable, ic_alloc, ic_unable, ic_over} <= 4'h0;
         {ic_flash, ic_abort} <= 2'h0;
         dc_count <= 8'h00;
         ic_count <= 8'h00;
         data_lock_syndrome <= 1'b0;
         instr_lock_syndrome <= 1'b0;
      end else begin
         if (wr_d) begin
            dc_enable <= w_data[`CSR_ENABLE_BIT];
            dc_alloc <= w_data[`CSR_OVERLOCK_ALLOC_BIT];
            dc_unable <= w_data[`CSR_UNABLE_BIT] | next_d_unable;
            dc_over <= w_data[`CSR_OVERLOCK_BIT] | next_d_over;
            dc_abort <= w_data[`CSR_ABORT_BIT] | (d_done & interrupt_pending);
         end else begin
            dc_unable <= dc_unable | next_d_unable;
            dc_over <= dc_over | next_d_over;
            dc_abort <= dc_abort | (d_done & interrupt_pending);
         end
         if (dc_flash) begin
            // Writes cannot touch the bit while clearing
            dc_count <= dc_count - 8'd1;
            dc_flash <= ~d_done;
         end else if (wr_d && w_data[`CSR_FLASH_CLEAR_BIT]) begin
            dc_flash <= 1'b1;
            dc_count <= `FLASH_CYCLES;
         end
         if (wr_i) begin
            ic_enable <= w_data[`CSR_ENABLE_BIT];
            ic_alloc <= w_data[`CSR_OVERLOCK_ALLOC_BIT];
            ic_unable <= w_data[`CSR_UNABLE_BIT] | next_i_unable;
            ic_over <= w_data[`CSR_OVERLOCK_BIT] | next_i_over;
            ic_abort <= w_data[`CSR_ABORT_BIT] | (i_done & interrupt_pending);
         end else begin
            ic_unable <= ic_unable | next_i_unable;
            ic_over <= ic_over | next_i_over;
            ic_abort <= ic_abort | (i_done & interrupt_pending);
         end
         if (ic_flash) begin
            ic_count <= ic_count - 8'd1;
            ic_flash <= ~i_done;
         end else if (wr_i && w_data[`CSR_FLASH_CLEAR_BIT]) begin
            ic_flash <= 1'b1;
            ic_count <= `FLASH_CYCLES;
         end
         data_lock_syndrome <= next_syn_d |
            (data_lock_syndrome & ~(wr_s & w_data[`SYN_DATA_LOCK_BIT]));
         instr_lock_syndrome <= next_syn_i |
            (instr_lock_syndrome & ~(wr_s & w_data[`SYN_INSTR_LOCK_BIT]));
      end
   end

endmodule // l1_cache_line_lock_control

// File: core/lock_ctrl_defines.vh
`ifndef LOCK_CTRL_DEFINES_VH
`define LOCK_CTRL_DEFINES_VH

// ****************************************
// Register map
// ****************************************
`define DCACHE_CTRL_OFFSET 8'h00
`define ICACHE_CTRL_OFFSET 8'h04
`define SYNDROME_OFFSET 8'h08

// ****************************************
// Control and status fields
// ****************************************
`define CSR_ENABLE_BIT 0
`define CSR_OVERLOCK_ALLOC_BIT 1
`define CSR_UNABLE_BIT 2
`define CSR_OVERLOCK_BIT 3
`define CSR_FLASH_CLEAR_BIT 4
`define CSR_ABORT_BIT 5
`define SYN_DATA_LOCK_BIT 0
`define SYN_INSTR_LOCK_BIT 1
`define CSR_RESET_VALUE 32'h0000_0000

// ****************************************
// Operation codes
// ****************************************
`define OP_NONE 4'h0
`define OP_DLOCK_SET 4'h1
`define OP_DSTORE_LOCK_SET 4'h2
`define OP_DLOCK_CLEAR 4'h3
`define OP_ILOCK_SET 4'h4
`define OP_ILOCK_CLEAR 4'h5
`define OP_ITOUCH 4'h6
`define OP_DALLOC 4'h7
`define OP_DZERO_ALLOC 4'h8
`define OP_DSTORE_FLUSH 4'h9
`define OP_DTOUCH 4'hA
`define OP_DTOUCH_STORE 4'hB
`define OP_DFLUSH_INV 4'hC
`define OP_DINV 4'hD
`define OP_IINV 4'hE

// ****************************************
// Geometry and timing
// ****************************************
`define SET_BITS 4
`define SETS 16
`define WAYS 4
`define WAY_BITS 2
`define FLASH_CYCLES 8'd134

`endif

// File: tb/lock_ctrl_asserts.sv
`timescale 1ns/1ps
`include "lock_ctrl_defines.vh"

module lock_ctrl_asserts (
   // Clock and reset
   input wire clock,
   input wire arst_n,
   // Request
   input wire op_valid,
   input wire [3:0] op_code,
   input wire [`SET_BITS-1:0] op_index,
   input wire [4:0] cache_target_field,
   input wire user_privilege_flag,
   input wire user_lock_enable,
   input wire line_hit,
   input wire tlb_miss,
   input wire perm_read,
   input wire perm_exec,
   input wire cache_inhibited,
   // Result
   input wire op_ready,
   input wire op_done,
   input wire data_storage_fault,
   input wire dtlb_error,
   input wire fill_req,
   input wire fill_icache,
   input wire [`SET_BITS-1:0] fill_index
);
   // Only a flash clear may stall requests for long
   reg [7:0] low_cnt;
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) low_cnt <= 8'h00;
      else if (op_ready) low_cnt <= 8'h00;
      else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence take_s;
      op_valid && op_ready;
   endsequence
   sequence lock_op_s;
      take_s ##0 (op_code inside {`OP_DLOCK_SET, `OP_DSTORE_LOCK_SET,
         `OP_DLOCK_CLEAR, `OP_ILOCK_SET, `OP_ILOCK_CLEAR});
   endsequence
   sequence plain_op_s;
      take_s ##0 (op_code >= `OP_ITOUCH);
   endsequence
   done_after_take_a: assert property (take_s |=> op_done && !op_ready)
      else $error("No op_done after a taken request");
   done_has_cause_a: assert property (op_done |-> $past(op_valid && op_ready))
      else $error("op_done without a request");
   result_with_done_a: assert property ((data_storage_fault || dtlb_error || fill_req) |-> op_done)
      else $error("Result pulse outside op_done");
   single_fault_a: assert property (op_done |-> !(data_storage_fault && dtlb_error))
      else $error("Two faults for one request");
   fill_target_a: assert property (take_s |=> (fill_req |-> fill_index == $past(op_index) && fill_icache == ($past(op_code) == `OP_ILOCK_SET)))
      else $error("Fill request for wrong cache or index");
   hit_no_fill_a: assert property (take_s ##0 line_hit |=> !fill_req)
      else $error("Fill issued on a hit");
   target_nop_a: assert property (lock_op_s ##0 (cache_target_field != 5'h00) |=> !data_storage_fault && !dtlb_error && !fill_req)
      else $error("Nonzero target not a no-op");
   inhibited_miss_a: assert property (take_s ##0 (op_code == `OP_ILOCK_SET && cache_inhibited && !line_hit && !tlb_miss && (perm_read || perm_exec) && (user_lock_enable || !user_privilege_flag)) |=> !data_storage_fault && !fill_req)
      else $error("Inhibited miss not a no-op");
   other_ops_a: assert property (plain_op_s |=> !fill_req && !data_storage_fault && !dtlb_error)
      else $error("Non-locking operation gave a result");
   no_tlb_a: assert property (take_s ##0 !tlb_miss |=> !dtlb_error)
      else $error("TLB error without a miss");
   busy_bound_a: assert property (low_cnt <= 8'd140)
      else $error("Request stall longer than a flash clear");
endmodule // lock_ctrl_asserts

// File: tb/pipe_model.sv
`timescale 1ns/1ps

module pipe_model (
   // Clock and handshake
   input wire clock,
   input wire op_ready,
   output reg op_valid,
   // Request fields
   output reg [3:0] op_code,
   output reg [3:0] op_index,
   output reg [4:0] cache_target_field,
   output reg user_privilege_flag,
   output reg user_lock_enable,
   // Lookup and translation
   output reg line_hit,
   output reg [1:0] hit_way,
   output reg tlb_miss,
   output reg perm_read,
   output reg perm_exec,
   output reg cache_inhibited
);
   initial begin
      op_valid = 1'b0;
      {cache_inhibited, perm_exec, perm_read, tlb_miss, hit_way, line_hit,
         user_lock_enable, user_privilege_flag, cache_target_field, op_index,
         op_code} = 22'h000000;
   end
   task issue(input [21:0] f, input integer gap);
      begin
         repeat (gap) @(posedge clock);
         {cache_inhibited, perm_exec, perm_read, tlb_miss, hit_way, line_hit,
            user_lock_enable, user_privilege_flag, cache_target_field,
            op_index, op_code} <= f;
         op_valid <= 1'b1;
         // Hold everything until the block takes it
         do @(posedge clock); while (!op_ready);
         op_valid <= 1'b0;
         // Released fields must not keep their last value
         {cache_inhibited, perm_exec, perm_read, tlb_miss, hit_way, line_hit,
            user_lock_enable, user_privilege_flag, cache_target_field,
            op_index, op_code} <= ~f;
      end
   endtask
endmodule // pipe_model

// File: tb/tb_l1_cache_line_lock_control.sv
`timescale 1ns/1ps
`include "lock_ctrl_defines.vh"

module tb_l1_cache_line_lock_control;
   reg clock = 1'b0, arst_n = 1'b0, interrupt_pending = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   reg s_axi_arvalid = 0, s_axi_rready = 0;
   wire [31:0] s_axi_rdata;
   wire [1:0] s_axi_bresp, s_axi_rresp, hit_way, fill_way;
   wire [3:0] op_code, op_index, fill_index;
   wire [4:0] cache_target_field;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, op_valid, user_privilege_flag, user_lock_enable;
   wire line_hit, tlb_miss, perm_read, perm_exec, cache_inhibited;
   wire op_ready, op_done, data_storage_fault, dtlb_error, fill_req;
   wire fill_icache;
   bit lk [0:1][0:15][0:3];
   reg [31:0] mcsr [0:1];
   reg [31:0] msyn, rd_val, d;
   reg [15:0] seed = 16'h0038, r1, r2;
   reg [21:0] f;
   reg [10:0] exp_res;
   integer cyc = 0, n_errors = 0, tests_run = 0, i, c, w, fw;

   l1_cache_line_lock_control u_l1_cache_line_lock_control (.*);
   pipe_model u_pipe_model (.*);

   always #2.5 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;

   // ****************************************
   // Bus and compare tasks
   // ****************************************
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk_reg(input string n, input [31:0] e, input logic [31:0] g);
      begin
         tests_run++;
         if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task chk_op(input string n, input [10:0] e, input logic [10:0] g);
      begin
         tests_run++;
         if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] dv, input [1:0] er);
      reg ad, dd;
      begin
         ad = 0;
         dd = 0;
         @(posedge clock);
         s_axi_awaddr <= a;
         s_axi_wdata <= dv;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         while (!(ad && dd)) begin
            @(posedge clock);
            if (!ad && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (!dd && s_axi_wready) s_axi_wvalid <= 1'b0;
            ad = ad | s_axi_awready;
            dd = dd | s_axi_wready;
         end
         while (!s_axi_bvalid) @(posedge clock);
         s_axi_bready <= 1'b0;
         chk_reg("bresp", er, s_axi_bresp);
      end
   endtask
   task rd(input [7:0] a, input [1:0] er);
      begin
         @(posedge clock);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do @(posedge clock); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         while (!s_axi_rvalid) @(posedge clock);
         s_axi_rready <= 1'b0;
         rd_val = s_axi_rdata;
         chk_reg("rresp", er, s_axi_rresp);
      end
   endtask

   // ****************************************
   // Reference model and scenarios
   // ****************************************
   task model_op;
      reg ic, en, perm, ls, lc;
      begin
         ic = f[3:0] inside {4'h4, 4'h5, 4'h6, 4'hE};
         en = mcsr[ic][0];
         perm = f[19] | (ic & f[20]);
         ls = f[3:0] inside {4'h1, 4'h2, 4'h4};
         lc = f[3:0] inside {4'h3, 4'h5};
         exp_res = 11'h400;
         fw = 4;
         if ((ls || lc) && (f[12:8] != 0 || !en)) mcsr[ic][2] |= ls;
         else if ((ls || lc) && f[18]) exp_res[8] = 1;
         else if ((ls || lc) && f[13] && !f[14]) begin
            exp_res[9] = 1;
            msyn[ic] = 1;
         end
         else if ((ls || lc) && !perm) exp_res[9] = 1;
         else if (ls && f[21] && !f[15]) mcsr[ic][2] = 1;
         else if ((ls || lc) && f[15]) lk[ic][f[7:4]][f[17:16]] = ls;
         else if (ls) begin
            for (w = 3; w >= 0; w--) if (!lk[ic][f[7:4]][w]) fw = w;
            if (fw == 4) begin
               mcsr[ic][3] = 1;
               fw = mcsr[ic][1] ? 0 : 4;
            end
            if (fw < 4) begin
               lk[ic][f[7:4]][fw] = 1;
               exp_res[10:0] = {4'h9, ic, f[7:4], fw[1:0]};
            end
         end
         else if (f[3:0] >= 4'hC && en && !f[18] && perm && f[15])
            lk[ic][f[7:4]][f[17:16]] = 0;
      end
   endtask
   task do_op(input integer gap);
      begin
         repeat (16) seed = lfsr(seed);
         r1 = seed;
         repeat (16) seed = lfsr(seed);
         r2 = seed;
         f = {r2[11] & r2[12], r2[10], r2[8] | r2[9], r2[7:5] == 3'h0,
            r1[12:8], r1[7:5] == 3'h0 ? {r2[4:1], 1'b1} : 5'h00,
            3'h0, r1[4], 4'h1 + (r1[3:0] % 4'hE)};
         u_pipe_model.issue(f, gap);
         model_op;
         @(negedge clock);
         chk_op("op_result", exp_res, {op_done, data_storage_fault, dtlb_error, fill_req, fill_req ? {fill_icache, fill_index, fill_way} : 7'h00});
      end
   endtask
   task run_ops(input integer n);
      for (i = 0; i < n; i++) begin
         do_op({30'h0, seed[15:14]});
         if (i % 8 == 7) begin
            rd(8'h04, 2'h0);
            chk_reg("icsr", mcsr[1], rd_val);
            rd(8'h00, 2'h0);
            chk_reg("dcsr", mcsr[0], rd_val);
            rd(8'h08, 2'h0);
            chk_reg("syndrome", msyn, rd_val);
            d = {seed, 12'h000, seed[3:1], seed[0] | seed[15]};
            c = seed[4];
            wr({5'h00, c[0], 2'h0}, d, 2'h0);
            mcsr[c] = {28'h0, d[3:0]};
            wr(8'h08, {30'h0, d[17:16]}, 2'h0);
            msyn = msyn & ~{30'h0, d[17:16]};
         end
      end
   endtask
   task close_out;
      begin
         if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask

   initial begin
      repeat (40000) @(posedge clock);
      n_errors++;
      close_out;
   end
   initial begin
      mcsr[0] = 0;
      mcsr[1] = 0;
      msyn = 0;
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      for (c = 0; c < 3; c++) begin
         rd(c * 4, 2'h0);
         chk_reg("reset_value", 32'h0, rd_val);
      end
      rd(8'h0C, 2'h3);
      chk_reg("unmapped", 32'h0, rd_val);
      wr(8'h10, 32'h1, 2'h3);
      s_axi_wstrb <= 4'hE;
      wr(8'h00, 32'h1, 2'h0);
      s_axi_wstrb <= 4'hF;
      rd(8'h00, 2'h0);
      chk_reg("strobe_off", 32'h0, rd_val);
      wr(8'h00, 32'h11, 2'h0);
      c = cyc;
      wr(8'h00, 32'h01, 2'h0);
      rd(8'h00, 2'h0);
      chk_reg("dcsr_busy", 32'h11, rd_val);
      while (rd_val[4]) rd(8'h00, 2'h0);
      chk_reg("clear_len", 1, cyc - c >= 130 && cyc - c <= 142);
      chk_reg("dcsr_done", 32'h1, rd_val);
      wr(8'h04, 32'h11, 2'h0);
      c = cyc;
      mcsr[0] = 1;
      mcsr[1] = 1;
      do_op(0);
      chk_reg("stall", 1, cyc - c >= 130);
      run_ops(160);
      wr(8'h04, mcsr[1] | 32'h10, 2'h0);
      repeat (5) @(posedge clock);
      interrupt_pending <= 1'b1;
      @(posedge clock);
      interrupt_pending <= 1'b0;
      rd(8'h04, 2'h0);
      mcsr[1][5] = 1;
      chk_reg("abort", mcsr[1], rd_val);
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      rd(8'h04, 2'h0);
      chk_reg("icsr_reset", 32'h0, rd_val);
      wr(8'h00, 32'h1, 2'h0);
      wr(8'h04, 32'h1, 2'h0);
      mcsr[0] = 1;
      mcsr[1] = 1;
      msyn = 0;
      run_ops(48);
      close_out;
   end
endmodule // tb_l1_cache_line_lock_control

bind l1_cache_line_lock_control lock_ctrl_asserts u_lock_ctrl_asserts (
   .clock, .arst_n, .op_valid, .op_code, .op_index, .cache_target_field,
   .user_privilege_flag, .user_lock_enable, .line_hit, .tlb_miss,
   .perm_read, .perm_exec, .cache_inhibited, .op_ready, .op_done,
   .data_storage_fault, .dtlb_error, .fill_req, .fill_icache, .fill_index);
